// ===== wmah_defines.svh
`ifndef WMAH_DEFINES_SVH
`define WMAH_DEFINES_SVH

// strobe levels on the memory-side cycle interface (all active low)
`define WMAH_ASSERTED   1'b0
`define WMAH_DEASSERTED 1'b1

// cycle kind encodings
`define WMAH_KIND_CPU     3'h0
`define WMAH_KIND_SNPWB   3'h1
`define WMAH_KIND_ALLOC   3'h2
`define WMAH_KIND_REPLWB  3'h3
`define WMAH_KIND_OTHER   3'h4

`define WMAH_RESP_RESET   2'h0

`endif

// ===== wmah_pkg.sv
`default_nettype none
`include "wmah_defines.svh"

package wmah_pkg;

  // kind of memory bus cycle being launched
  typedef enum logic [2:0] {
    WMAH_CPU   = 3'h0,
    WMAH_SNPWB = 3'h1,
    WMAH_ALLOC = 3'h2,
    WMAH_REPLWB = 3'h3,
    WMAH_OTHER = 3'h4
  } wmah_kind_t;

  // state of the memory-side cycle tracker
  typedef enum logic [1:0] {
    WMAH_IDLE    = 2'b00,
    WMAH_ACTIVE  = 2'b01,
    WMAH_SAMPLED = 2'b10
  } wmah_state_t;

endpackage : wmah_pkg

`default_nettype wire

// ===== wmah_cyc_if.sv
`timescale 1ns/100ps
`default_nettype none

// cycle description passed from the top to the qualifier
interface wmah_cyc_if;
  logic                   l2_miss;
  logic                   page_cache_disable;
  logic                   page_write_through;
  logic                   lock_n;
  logic                   write_not_read;
  logic                   data_not_code;
  logic                   mem_not_io;
  wmah_pkg::wmah_kind_t   kind;
  logic                   candidate;

  modport src (output l2_miss, page_cache_disable, page_write_through, lock_n,
               write_not_read, data_not_code, mem_not_io, kind, input candidate);
  modport qual (input l2_miss, page_cache_disable, page_write_through, lock_n,
                input write_not_read, data_not_code, mem_not_io, kind, output candidate);
endinterface : wmah_cyc_if

`default_nettype wire

// ===== wmah_qualify.sv
`timescale 1ns/100ps
`default_nettype none
`include "wmah_defines.svh"

// combinational write-miss allocate qualifier
module wmah_qualify
(
  wmah_cyc_if.qual cyc
);

  // only cpu memory data write misses with normal page attributes and no lock
  always_comb
  begin
    cyc.candidate = (cyc.kind == wmah_pkg::WMAH_CPU)
                  & cyc.l2_miss
                  & ~cyc.page_cache_disable
                  & ~cyc.page_write_through
                  & (cyc.lock_n == `WMAH_DEASSERTED)
                  & cyc.write_not_read
                  & cyc.data_not_code
                  & cyc.mem_not_io;
  end

endmodule // wmah_qualify

`default_nettype wire

// ===== wmah_hint.sv
`timescale 1ns/100ps
`default_nettype none
`include "wmah_defines.svh"

module wmah_hint
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       start,               // launch a memory bus cycle
  input  wire logic       snoop,               // launched cycle is a snoop cycle
  input  wire logic [2:0] cycle_kind,
  input  wire logic       l2_miss,
  input  wire logic       page_cache_disable,
  input  wire logic       page_write_through,
  input  wire logic       lock_n,
  input  wire logic       write_not_read,
  input  wire logic       data_not_code,
  input  wire logic       mem_not_io,
  input  wire logic       uses_attr_window,
  input  wire logic       cycle_done_n,
  input  wire logic       cycle_next_addr_n,
  input  wire logic       attr_window_strobe_n,
  input  wire logic       mem_cacheable_resp_n,
  input  wire logic       mem_read_only_resp_n,
  output logic            cycle_addr_strobe_n,
  output logic            snoop_addr_strobe_n,
  output logic            potential_allocate_n,
  output logic            alloc_granted,
  output logic            alloc_read_only,
  output logic            resp_valid
);

  wmah_cyc_if cyc ();
  wmah_pkg::wmah_state_t state;
  wmah_pkg::wmah_state_t next_state;
  logic                  strobe_q;
  logic                  cycle_end;
  logic                  attr_in;
  logic                  launch;

  assign cyc.l2_miss            = l2_miss;
  assign cyc.page_cache_disable = page_cache_disable;
  assign cyc.page_write_through = page_write_through;
  assign cyc.lock_n             = lock_n;
  assign cyc.write_not_read     = write_not_read;
  assign cyc.data_not_code      = data_not_code;
  assign cyc.mem_not_io         = mem_not_io;
  assign cyc.kind               = wmah_pkg::wmah_kind_t'(cycle_kind);

  wmah_qualify u_qual
  (
    .cyc (cyc)
  );

  // a cycle is over on either cycle-done or next-address from the far side
  assign cycle_end = strobe_q & ((cycle_done_n == `WMAH_ASSERTED)
                   | (cycle_next_addr_n == `WMAH_ASSERTED));
  assign attr_in   = (attr_window_strobe_n == `WMAH_ASSERTED);
  // a new cycle is taken when idle or as the old one ends
  assign launch    = start & ((state == wmah_pkg::WMAH_IDLE) | cycle_end);

  // cycle tracker
  always_comb
  begin
    next_state = state;
    unique case (state)
      wmah_pkg::WMAH_IDLE:
        if (launch)
          next_state = wmah_pkg::WMAH_ACTIVE;
      wmah_pkg::WMAH_ACTIVE, wmah_pkg::WMAH_SAMPLED:
        if (launch)
          next_state = wmah_pkg::WMAH_ACTIVE;
        else if (cycle_end)
          next_state = wmah_pkg::WMAH_IDLE;
        else if (attr_in & uses_attr_window)
          next_state = wmah_pkg::WMAH_SAMPLED;
      default:
        next_state = wmah_pkg::WMAH_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      state <= wmah_pkg::WMAH_IDLE;
    else
      state <= next_state;
  end

  // one-cycle address strobes, cycle or snoop flavour
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cycle_addr_strobe_n <= `WMAH_DEASSERTED;
      snoop_addr_strobe_n <= `WMAH_DEASSERTED;
    end
    else
    begin
      cycle_addr_strobe_n <= (launch & ~snoop) ? `WMAH_ASSERTED : `WMAH_DEASSERTED;
      snoop_addr_strobe_n <= (launch & snoop) ? `WMAH_ASSERTED : `WMAH_DEASSERTED;
    end
  end

  // strobes are driven from a flop, so end detection waits one cycle past them
  always_ff @(posedge clk)
  begin
    if (!nrst)
      strobe_q <= 1'b0;
    else if (launch)
      strobe_q <= 1'b0;
    else if (state != wmah_pkg::WMAH_IDLE)
      strobe_q <= 1'b1;
    else
      strobe_q <= 1'b0;
  end

  // hint loads with the strobe and holds; snoop cycles never carry it
  always_ff @(posedge clk)
  begin
    if (!nrst)
      potential_allocate_n <= `WMAH_DEASSERTED;
    else if (launch)
      potential_allocate_n <= (cyc.candidate & ~snoop)
                              ? `WMAH_ASSERTED : `WMAH_DEASSERTED;
    else if (cycle_end)
      potential_allocate_n <= `WMAH_DEASSERTED;
  end

  // decision of the bus controller, taken once per cycle at the window strobe when uses_attr_window is set
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      {alloc_granted, alloc_read_only} <= `WMAH_RESP_RESET;
      resp_valid <= 1'b0;
    end
    else if (launch)
    begin
      {alloc_granted, alloc_read_only} <= `WMAH_RESP_RESET;
      resp_valid <= 1'b0;
    end
    else if (state == wmah_pkg::WMAH_ACTIVE && strobe_q && attr_in && uses_attr_window)
    begin
      alloc_granted   <= (mem_cacheable_resp_n == `WMAH_ASSERTED)
                         & (potential_allocate_n == `WMAH_ASSERTED);
      alloc_read_only <= (mem_read_only_resp_n == `WMAH_ASSERTED);
      resp_valid      <= 1'b1;
    end
  end

  AST_HINT_WITH_STROBE: assert property (@(posedge clk) disable iff (!nrst)
    (potential_allocate_n == `WMAH_ASSERTED) && $fell(potential_allocate_n)
    |-> (cycle_addr_strobe_n == `WMAH_ASSERTED))
    else $error("hint rose without a cycle address strobe");

  AST_HINT_STABLE: assert property (@(posedge clk) disable iff (!nrst)
    (state != wmah_pkg::WMAH_IDLE) && !cycle_end && !launch
    |=> $stable(potential_allocate_n))
    else $error("hint changed inside a cycle");

  AST_NO_SNOOP_HINT: assert property (@(posedge clk) disable iff (!nrst)
    (snoop_addr_strobe_n == `WMAH_ASSERTED) |-> (potential_allocate_n == `WMAH_DEASSERTED))
    else $error("hint on snoop cycle");

  AST_QUALIFY: assert property (@(posedge clk) disable iff (!nrst)
    launch && !snoop && (page_cache_disable || page_write_through || !l2_miss
      || lock_n == `WMAH_ASSERTED || !write_not_read || !mem_not_io || !data_not_code)
    |=> (potential_allocate_n == `WMAH_DEASSERTED))
    else $error("hint for non-qualifying cycle");

  AST_ASSERT_ON_CANDIDATE: assert property (@(posedge clk) disable iff (!nrst)
    launch && !snoop && cyc.candidate |=> (potential_allocate_n == `WMAH_ASSERTED))
    else $error("qualifying write miss not flagged");

  AST_KIND_BLOCK: assert property (@(posedge clk) disable iff (!nrst)
    launch && (cyc.kind != wmah_pkg::WMAH_CPU) |=> potential_allocate_n)
    else $error("hint on writeback or allocation cycle");

  AST_SAMPLE: assert property (@(posedge clk) disable iff (!nrst)
    (state == wmah_pkg::WMAH_ACTIVE) && strobe_q && attr_in && uses_attr_window && !launch
    |=> resp_valid && (alloc_read_only == !$past(mem_read_only_resp_n)))
    else $error("responses not sampled at window strobe");

  AST_GRANT_NEEDS_HINT: assert property (@(posedge clk) disable iff (!nrst)
    $rose(alloc_granted) |-> ($past(potential_allocate_n) == `WMAH_ASSERTED))
    else $error("grant without hint");

  // a start mid-cycle is dropped, not queued: the requester must hold it to the end
  AST_REFUSE_MID_CYCLE: assert property (@(posedge clk) disable iff (!nrst)
    start && (state != wmah_pkg::WMAH_IDLE) && !cycle_end
    |=> (cycle_addr_strobe_n == `WMAH_DEASSERTED)
        && (snoop_addr_strobe_n == `WMAH_DEASSERTED))
    else $error("address strobe for a start that came mid-cycle");

  AST_STROBE_PULSE: assert property (@(posedge clk) disable iff (!nrst)
    (cycle_addr_strobe_n == `WMAH_ASSERTED) |=> (cycle_addr_strobe_n == `WMAH_DEASSERTED))
    else $error("cycle address strobe longer than one cycle");

  AST_HINT_OFF_AT_END: assert property (@(posedge clk) disable iff (!nrst)
    cycle_end && !launch |=> (potential_allocate_n == `WMAH_DEASSERTED))
    else $error("hint left on after the cycle ended");

  AST_RESP_AT_WINDOW: assert property (@(posedge clk) disable iff (!nrst)
    $rose(resp_valid) |-> $past(attr_in) && $past(uses_attr_window))
    else $error("responses taken outside the window strobe");

  AST_RESP_CLEARED: assert property (@(posedge clk) disable iff (!nrst)
    launch |=> !resp_valid && !alloc_granted && !alloc_read_only)
    else $error("old responses kept into a new cycle");

  COV_HINT: cover property (@(posedge clk) disable iff (!nrst)
    $fell(potential_allocate_n));
  COV_GRANT: cover property (@(posedge clk) disable iff (!nrst) $rose(alloc_granted));
  COV_SNOOP: cover property (@(posedge clk) disable iff (!nrst)
    snoop_addr_strobe_n == `WMAH_ASSERTED);
  COV_BACK2BACK: cover property (@(posedge clk) disable iff (!nrst) cycle_end && launch);
  COV_SAMPLED: cover property (@(posedge clk) disable iff (!nrst) $rose(resp_valid));

endmodule // wmah_hint

`default_nettype wire

// ===== wmah_mbc_model.sv
`timescale 1ns/100ps
`default_nettype none

// bus controller stand-in: window one cycle after an address strobe,
// then done or next-address after wait_cycles extra cycles
module wmah_mbc_model
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       cycle_addr_strobe_n,
  input  wire logic       snoop_addr_strobe_n,
  input  wire logic       grant,
  input  wire logic       read_only,
  input  wire logic       use_next,
  input  wire logic [1:0] wait_cycles,
  output logic            attr_window_strobe_n,
  output logic            mem_cacheable_resp_n,
  output logic            mem_read_only_resp_n,
  output logic            cycle_done_n,
  output logic            cycle_next_addr_n
);
  logic [2:0] phase;

  // hint is never looked at here, so its value outside a cycle is free
  // responses toggle outside the window so a stray sample is never stable
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      attr_window_strobe_n <= 1'b1;
      mem_cacheable_resp_n <= 1'b1;
      mem_read_only_resp_n <= 1'b1;
      cycle_done_n         <= 1'b1;
      cycle_next_addr_n    <= 1'b1;
      phase                <= 3'h0;
    end
    else
    begin
      attr_window_strobe_n <= 1'b1;
      cycle_done_n         <= 1'b1;
      cycle_next_addr_n    <= 1'b1;
      mem_cacheable_resp_n <= ~mem_cacheable_resp_n;
      mem_read_only_resp_n <= ~mem_read_only_resp_n;
      if (!cycle_addr_strobe_n || !snoop_addr_strobe_n)
      begin
        attr_window_strobe_n <= 1'b0;
        mem_cacheable_resp_n <= ~grant;
        mem_read_only_resp_n <= ~read_only;
        phase                <= {1'b0, wait_cycles} + 3'h1;
      end
      else if (phase == 3'h1)
      begin
        cycle_next_addr_n <= ~use_next;
        cycle_done_n      <= use_next;
        phase             <= 3'h0;
      end
      else if (phase != 3'h0)
        phase <= phase - 3'h1;
    end
  end
endmodule // wmah_mbc_model

`default_nettype wire

// ===== write_miss_allocate_hint_bench.sv
`timescale 1ns/100ps
`default_nettype none

module write_miss_allocate_hint_bench;
  logic clk, nrst, start, snoop, l2_miss, page_cache_disable, page_write_through, lock_n;
  logic write_not_read, data_not_code, mem_not_io, uses_attr_window, grant, read_only, use_next;
  logic [2:0] cycle_kind;
  logic [1:0] wait_cycles;
  logic cycle_done_n, cycle_next_addr_n, attr_window_strobe_n, mem_cacheable_resp_n;
  logic mem_read_only_resp_n, cycle_addr_strobe_n, snoop_addr_strobe_n, potential_allocate_n;
  logic alloc_granted, alloc_read_only, resp_valid;
  int   fail_count, num_checks;

  wmah_hint wmah_hint_inst (.clk(clk), .nrst(nrst), .start(start), .snoop(snoop),
    .cycle_kind(cycle_kind), .l2_miss(l2_miss), .page_cache_disable(page_cache_disable),
    .page_write_through(page_write_through), .lock_n(lock_n), .write_not_read(write_not_read),
    .data_not_code(data_not_code), .mem_not_io(mem_not_io), .uses_attr_window(uses_attr_window),
    .cycle_done_n(cycle_done_n), .cycle_next_addr_n(cycle_next_addr_n),
    .attr_window_strobe_n(attr_window_strobe_n), .mem_cacheable_resp_n(mem_cacheable_resp_n),
    .mem_read_only_resp_n(mem_read_only_resp_n), .cycle_addr_strobe_n(cycle_addr_strobe_n),
    .snoop_addr_strobe_n(snoop_addr_strobe_n), .potential_allocate_n(potential_allocate_n),
    .alloc_granted(alloc_granted), .alloc_read_only(alloc_read_only), .resp_valid(resp_valid));

  wmah_mbc_model wmah_mbc_model_inst (.clk(clk), .nrst(nrst),
    .cycle_addr_strobe_n(cycle_addr_strobe_n), .snoop_addr_strobe_n(snoop_addr_strobe_n),
    .grant(grant), .read_only(read_only), .use_next(use_next), .wait_cycles(wait_cycles),
    .attr_window_strobe_n(attr_window_strobe_n), .mem_cacheable_resp_n(mem_cacheable_resp_n),
    .mem_read_only_resp_n(mem_read_only_resp_n), .cycle_done_n(cycle_done_n),
    .cycle_next_addr_n(cycle_next_addr_n));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string n, input logic e, input logic s);
    num_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %b seen %b", n, e, s);
    end
  endtask

  // one whole cycle; a = {miss, pcd, pwt, lock_n, write, data, mem}
  task automatic run(input logic [6:0] a, input logic [2:0] k, input logic snp,
                     input logic u, input logic g, input logic r, input logic nx,
                     input logic [1:0] w);
    logic h;
    logic fin;
    h = (a == 7'h4F) && (k == 3'h0) && !snp;
    fin = 1'b0;
    @(posedge clk);
    {l2_miss, page_cache_disable, page_write_through, lock_n} <= a[6:3];
    {write_not_read, data_not_code, mem_not_io} <= a[2:0];
    {cycle_kind, snoop, uses_attr_window} <= {k, snp, u};
    {grant, read_only, use_next, wait_cycles} <= {g, r, nx, w};
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    chk("strobe", 1'b0, snp ? snoop_addr_strobe_n : cycle_addr_strobe_n);
    chk("hint", !h, potential_allocate_n);
    for (int i = 0; i < 8 && !fin; i++)
    begin
      @(posedge clk);
      #1;
      fin = !(cycle_done_n && cycle_next_addr_n);
      chk("hint held", !h, potential_allocate_n);
    end
    chk("cycle end", 1'b1, fin);
    chk("granted", h & g & u, alloc_granted);
    chk("read only", r & u, alloc_read_only);
    chk("resp valid", u, resp_valid);
    @(posedge clk);
    #1;
    chk("hint idle", 1'b1, potential_allocate_n);
  endtask

  task automatic t_alloc();
    run(7'h4F, 3'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
    run(7'h4F, 3'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 2'h0);
    run(7'h4F, 3'h0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 2'h1);
  endtask

  // each qualifying term broken in turn, write hit included
  task automatic t_blocked();
    for (int i = 0; i < 7; i++)
      run(7'h4F ^ (7'h01 << i), 3'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
  endtask

  task automatic t_kinds();
    for (int k = 1; k < 5; k++)
      run(7'h4F, 3'(k), k == 1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
  endtask

  // no window use: responses must be left alone; slow end by next-address
  task automatic t_window_and_end();
    run(7'h4F, 3'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 2'h0);
    run(7'h4F, 3'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 2'h3);
  endtask

  // start held through a cycle: refused mid-cycle, taken again at the end edge
  task automatic t_back2back();
    @(posedge clk);
    {l2_miss, page_cache_disable, page_write_through, lock_n} <= 4'h9;
    {write_not_read, data_not_code, mem_not_io} <= 3'h7;
    {cycle_kind, snoop, uses_attr_window} <= 5'h01;
    {grant, read_only, use_next, wait_cycles} <= 5'h10;
    start <= 1'b1;
    @(posedge clk);
    #1;
    chk("first strobe", 1'b0, cycle_addr_strobe_n);
    @(posedge clk);
    #1;
    chk("refused strobe", 1'b1, cycle_addr_strobe_n);
    repeat (2) @(posedge clk);
    start <= 1'b0;
    #1;
    chk("b2b strobe", 1'b0, cycle_addr_strobe_n);
    chk("b2b hint", 1'b0, potential_allocate_n);
    chk("b2b valid", 1'b0, resp_valid);
    repeat (3) @(posedge clk);
    #1;
    chk("b2b granted", 1'b1, alloc_granted);
    chk("b2b hint idle", 1'b1, potential_allocate_n);
  endtask

  // reset pulled inside a flagged cycle must drop the hint at the next clock edge
  task automatic t_reset_mid();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    nrst <= 1'b0;
    #1;
    chk("hint before reset", 1'b0, potential_allocate_n);
    @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("hint after reset", 1'b1, potential_allocate_n);
    chk("valid after reset", 1'b0, resp_valid);
    repeat (2) @(posedge clk);
    #1;
    chk("strobe after reset", 1'b1, cycle_addr_strobe_n);
  endtask

  initial
  begin
    {nrst, start, snoop, l2_miss, page_cache_disable, page_write_through} = 6'h00;
    {lock_n, write_not_read, data_not_code, mem_not_io, uses_attr_window} = 5'h00;
    {cycle_kind, grant, read_only, use_next, wait_cycles} = 8'h00;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("reset hint", 1'b1, potential_allocate_n);
    chk("reset valid", 1'b0, resp_valid);
    t_alloc();
    t_blocked();
    t_kinds();
    t_window_and_end();
    t_back2back();
    t_reset_mid();
    tally_and_finish();
  end

  // the sequence needs well under 400 cycles
  initial
  begin
    repeat (2000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule // write_miss_allocate_hint_bench

`default_nettype wire
